/* File: core_sfr_file.v */
// Purpose: core register set, banked registers and scratch memory over apb
// Assumes: apb byte address = index * 4; data in bits 7:0, upper bits read 0
// Notes: an operation port drives the arithmetic, stack and flag updates
`include "core_sfr_map.vh"
module core_sfr_file #(
  parameter CODE_ADDR_W = 16,
  parameter DATA_ADDR_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg [DATA_ADDR_W-1:0] data_pointer_addr,
  output reg [DATA_ADDR_W-1:0] paged_data_addr,
  output reg serial_rate_double,
  output reg code_store_write_mode
);
  reg [7:0] stack_top_pointer_q;
  reg [7:0] data_pointer_low_q, data_pointer_high_q;
  reg [7:0] second_pointer_low_q, second_pointer_high_q;
  reg [7:0] power_control_q;
  reg pointer_select_q;
  reg [7:0] paged_data_high_byte_q;
  reg [7:0] status_q;
  reg [7:0] main_operand_q;
  reg [7:0] multiply_aux_q;
  reg [7:0] op_arg_q;
  reg [15:0] ret_addr_q;
  reg ret_phase_q;
  reg [3:0] cmd_q;
  reg [7:0] op_info_q;

  wire [9:0] idx = paddr[11:2];
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire odd_ones = ^main_operand_q;
  wire [7:0] status_rd = {status_q[7:1], odd_ones};
  wire [1:0] bank_select = status_q[`ST_BANK_HI:`ST_BANK_LO];

  // engine side of scratch memory
  reg eng_we;
  reg [7:0] eng_addr;
  reg [7:0] eng_wdata;
  wire [7:0] eng_rdata;
  wire [7:0] bus_rdata;
  wire bus_scratch = (idx[9:8] == 2'b10);
  wire bus_we = wr && bus_scratch && pready == 1'b0;

  // working register or bit byte address inside scratch memory
  function [7:0] bank_reg_addr;
    input [1:0] bank;
    input [2:0] reg_no;
    begin
      bank_reg_addr = {3'b000, bank, reg_no};
    end
  endfunction

  function [7:0] bit_byte_addr;
    input [7:0] bit_addr;
    begin
      bit_byte_addr = {4'h2, bit_addr[6:3]};
    end
  endfunction

  scratch_ram ram_u (
    .pclk(pclk),
    .a_we(bus_we),
    .a_addr(idx[7:0]),
    .a_wdata(pwdata[7:0]),
    .a_rdata(bus_rdata),
    .b_we(eng_we),
    .b_addr(eng_addr),
    .b_wdata(eng_wdata),
    .b_rdata(eng_rdata)
  );

  wire [7:0] alu_a, alu_b;
  wire alu_c, alu_h, alu_v;
  operand_alu alu_u (
    .cmd(cmd_q),
    .a(main_operand_q),
    .b((cmd_q == `CMD_MUL || cmd_q == `CMD_DIV) ? multiply_aux_q : op_arg_q),
    .carry_in(status_q[`ST_CARRY]),
    .res_a(alu_a),
    .res_b(alu_b),
    .carry_out(alu_c),
    .half_out(alu_h),
    .range_out(alu_v)
  );

  // engine address: stack slot, working register or bit byte
  wire [7:0] stack_next = stack_top_pointer_q + 8'h01;
  wire bit_sfr = op_arg_q[7];
  wire [7:0] bit_mask = 8'h01 << op_arg_q[2:0];
  always @* begin
    eng_we = 1'b0;
    eng_addr = stack_top_pointer_q;
    eng_wdata = 8'h00;
    case (cmd_q)
      `CMD_PUSH: begin
        eng_we = 1'b1;
        eng_addr = stack_next;
        eng_wdata = op_arg_q;
      end
      `CMD_CALL: begin
        eng_we = 1'b1;
        eng_addr = stack_next;
        eng_wdata = ret_phase_q ? ret_addr_q[15:8] : ret_addr_q[7:0];
      end
      `CMD_BITC: begin
        eng_addr = bit_byte_addr(op_arg_q);
      end
      `CMD_NONE: begin
        eng_addr = bank_reg_addr(bank_select, op_arg_q[2:0]);
      end
      default: begin
        eng_addr = stack_top_pointer_q;
      end
    endcase
  end

  // bit read: scratch byte below 0x80, sfr column 000 at or above
  reg bit_val;
  always @* begin
    bit_val = 1'b0;
    if (!bit_sfr) begin
      bit_val = |(eng_rdata & bit_mask);
    end else begin
      case ({op_arg_q[7:3], 3'b000})
        `SFR_STATUS_IDX: bit_val = |(status_rd & bit_mask);
        `SFR_OPERAND_IDX: bit_val = |(main_operand_q & bit_mask);
        `SFR_AUX_IDX: bit_val = |(multiply_aux_q & bit_mask);
        default: bit_val = 1'b0;
      endcase
    end
  end

  // register read mux
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    case (idx)
      {2'b00, `SFR_STACK_IDX}: rd_byte = stack_top_pointer_q;
      {2'b00, `SFR_DPTR0_LO_IDX}: rd_byte = data_pointer_low_q;
      {2'b00, `SFR_DPTR0_HI_IDX}: rd_byte = data_pointer_high_q;
      {2'b00, `SFR_DPTR1_LO_IDX}: rd_byte = second_pointer_low_q;
      {2'b00, `SFR_DPTR1_HI_IDX}: rd_byte = second_pointer_high_q;
      {2'b00, `SFR_POWER_CTRL_IDX}: rd_byte = power_control_q & `POWER_ZERO_MASK;
      {2'b00, `SFR_PTR_SELECT_IDX}: rd_byte = {7'h00, pointer_select_q};
      {2'b00, `SFR_PAGE_HIGH_IDX}: rd_byte = paged_data_high_byte_q;
      {2'b00, `SFR_STATUS_IDX}: rd_byte = status_rd;
      {2'b00, `SFR_OPERAND_IDX}: rd_byte = main_operand_q;
      {2'b00, `SFR_AUX_IDX}: rd_byte = multiply_aux_q;
      `OP_ARG_IDX: rd_byte = op_arg_q;
      `OP_INFO_IDX: rd_byte = op_info_q;
      default: rd_byte = bus_scratch ? bus_rdata : 8'h00;
    endcase
  end

  function mapped;
    input [9:0] i;
    begin
      mapped = (i[9:8] == 2'b10) || (i == `OP_CMD_IDX) || (i == `OP_ARG_IDX) ||
        (i == `OP_INFO_IDX) || (i == {2'b00, `SFR_STACK_IDX}) ||
        (i >= {2'b00, `SFR_DPTR0_LO_IDX} && i <= {2'b00, `SFR_DPTR1_HI_IDX}) ||
        (i == {2'b00, `SFR_POWER_CTRL_IDX}) || (i == {2'b00, `SFR_PTR_SELECT_IDX}) ||
        (i == {2'b00, `SFR_PAGE_HIGH_IDX}) || (i == {2'b00, `SFR_STATUS_IDX}) ||
        (i == {2'b00, `SFR_OPERAND_IDX}) || (i == {2'b00, `SFR_AUX_IDX});
    end
  endfunction

  // apb: one wait state, then ready for one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !mapped(idx);
      if (access && !pready && !pwrite) begin
        prdata <= {24'h000000, rd_byte};
      end
    end
  end

  wire wr_go = wr && !pready;
  wire [7:0] wb = pwdata[7:0];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_top_pointer_q <= `STACK_RESET;
      data_pointer_low_q <= `BYTE_RESET;
      data_pointer_high_q <= `BYTE_RESET;
      second_pointer_low_q <= `BYTE_RESET;
      second_pointer_high_q <= `BYTE_RESET;
      power_control_q <= `BYTE_RESET;
      pointer_select_q <= 1'b0;
      paged_data_high_byte_q <= `PAGE_RESET;
      status_q <= `BYTE_RESET;
      main_operand_q <= `BYTE_RESET;
      multiply_aux_q <= `BYTE_RESET;
      op_arg_q <= `BYTE_RESET;
      ret_addr_q <= 16'h0000;
      ret_phase_q <= 1'b0;
      cmd_q <= `CMD_NONE;
      op_info_q <= `BYTE_RESET;
    end else begin
      if (wr_go) begin
        case (idx)
          {2'b00, `SFR_STACK_IDX}: stack_top_pointer_q <= wb;
          {2'b00, `SFR_DPTR0_LO_IDX}: data_pointer_low_q <= wb;
          {2'b00, `SFR_DPTR0_HI_IDX}: data_pointer_high_q <= wb;
          {2'b00, `SFR_DPTR1_LO_IDX}: second_pointer_low_q <= wb;
          {2'b00, `SFR_DPTR1_HI_IDX}: second_pointer_high_q <= wb;
          // bits 1:0 kept clear whatever software writes
          {2'b00, `SFR_POWER_CTRL_IDX}: power_control_q <= wb & `POWER_ZERO_MASK;
          {2'b00, `SFR_PTR_SELECT_IDX}: pointer_select_q <= wb[0];
          {2'b00, `SFR_PAGE_HIGH_IDX}: paged_data_high_byte_q <= wb;
          // parity bit is never stored
          {2'b00, `SFR_STATUS_IDX}: status_q <= {wb[7:1], 1'b0};
          {2'b00, `SFR_OPERAND_IDX}: main_operand_q <= wb;
          {2'b00, `SFR_AUX_IDX}: multiply_aux_q <= wb;
          `OP_ARG_IDX: op_arg_q <= wb;
          `OP_CMD_IDX: begin
            cmd_q <= pwdata[3:0];
            ret_addr_q <= pwdata[23:8];
            ret_phase_q <= 1'b0;
          end
          default: op_info_q <= op_info_q;
        endcase
      end else begin
        // one-step operations retire here; call and return take two steps
        case (cmd_q)
          `CMD_ADD, `CMD_ADDC, `CMD_SUBB, `CMD_MUL, `CMD_DIV: begin
            main_operand_q <= alu_a;
            status_q[`ST_CARRY] <= alu_c;
            status_q[`ST_RANGE] <= alu_v;
            // aux keeps its scratch value except for multiply and divide
            if (cmd_q != `CMD_MUL && cmd_q != `CMD_DIV) begin
              status_q[`ST_HALF] <= alu_h;
            end else begin
              multiply_aux_q <= alu_b;
            end
            cmd_q <= `CMD_NONE;
          end
          `CMD_PUSH: begin
            stack_top_pointer_q <= stack_next;
            cmd_q <= `CMD_NONE;
          end
          `CMD_CALL: begin
            stack_top_pointer_q <= stack_next;
            ret_phase_q <= 1'b1;
            if (ret_phase_q) begin
              cmd_q <= `CMD_NONE;
            end
          end
          `CMD_POP, `CMD_RET: begin
            op_info_q <= eng_rdata;
            stack_top_pointer_q <= stack_top_pointer_q - 8'h01;
            ret_phase_q <= 1'b1;
            if (cmd_q == `CMD_POP || ret_phase_q) begin
              cmd_q <= `CMD_NONE;
            end
          end
          `CMD_SETC: begin
            status_q[`ST_CARRY] <= 1'b1;
            cmd_q <= `CMD_NONE;
          end
          `CMD_CLRC: begin
            status_q[`ST_CARRY] <= 1'b0;
            cmd_q <= `CMD_NONE;
          end
          `CMD_CPLC: begin
            status_q[`ST_CARRY] <= ~status_q[`ST_CARRY];
            cmd_q <= `CMD_NONE;
          end
          `CMD_BITC: begin
            status_q[`ST_CARRY] <= bit_val;
            cmd_q <= `CMD_NONE;
          end
          default: begin
            // idle: nothing retires
            // op info keeps the last popped byte until the next pop or return
          end
        endcase
      end
    end
  end

  // pin views; registered so a select write shows on the next cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_pointer_addr <= {DATA_ADDR_W{1'b0}};
      paged_data_addr <= {DATA_ADDR_W{1'b0}};
      serial_rate_double <= 1'b0;
      code_store_write_mode <= 1'b0;
    end else begin
      data_pointer_addr <= pointer_select_q ?
        {second_pointer_high_q, second_pointer_low_q} :
        {data_pointer_high_q, data_pointer_low_q};
      paged_data_addr <= {paged_data_high_byte_q, eng_rdata};
      serial_rate_double <= power_control_q[`POWER_RATE_DOUBLE];
      code_store_write_mode <= power_control_q[`POWER_CODE_WRITE];
    end
  end

  // address space widths
  wire [CODE_ADDR_W-1:0] code_space_top = {CODE_ADDR_W{1'b1}};
endmodule

/* File: core_sfr_file_monitor.sv */
// Purpose: bus timing and output checks for the core register set
// Assumes: byte address = index * 4, one wait state per transfer
// Notes: shadow copies follow bus writes only; ops never touch them
module core_sfr_file_monitor #(
  parameter CODE_ADDR_W = 16,
  parameter DATA_ADDR_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [DATA_ADDR_W-1:0] data_pointer_addr,
  input wire logic [DATA_ADDR_W-1:0] paged_data_addr,
  input wire logic serial_rate_double,
  input wire logic code_store_write_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [9:0] idx;
  logic done_w;
  logic mapped;
  logic [7:0] ptr0_lo_q, ptr0_hi_q, ptr1_lo_q, ptr1_hi_q, sel_q, page_q, power_q;
  logic [2:0] quiet_q;
  assign idx = paddr[11:2];
  assign done_w = psel && penable && pready && pwrite;
  assign mapped = (idx inside {10'h081, 10'h082, 10'h083, 10'h084, 10'h085, 10'h087, 10'h092,
    10'h0C9, 10'h0D0, 10'h0E0, 10'h0F0, 10'h100, 10'h101, 10'h102}) || (idx[9:8] == 2'b10);
  // outputs may lag a write, so compare only after a quiet spell
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ptr0_lo_q, ptr0_hi_q, ptr1_lo_q, ptr1_hi_q, sel_q, page_q, power_q} <= '0;
      quiet_q <= 3'h0;
    end else begin
      quiet_q <= done_w ? 3'h0 : (quiet_q == 3'h7 ? quiet_q : quiet_q + 3'h1);
      if (done_w) begin
        case (idx)
          10'h082: ptr0_lo_q <= pwdata[7:0];
          10'h083: ptr0_hi_q <= pwdata[7:0];
          10'h084: ptr1_lo_q <= pwdata[7:0];
          10'h085: ptr1_hi_q <= pwdata[7:0];
          10'h087: power_q <= pwdata[7:0];
          10'h092: sel_q <= pwdata[7:0];
          10'h0C9: page_q <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_done;
    s_access ##0 pready;
  endsequence
  chk_one_wait:
    assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not after exactly one wait state");
  chk_ready_pulse:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  chk_ready_access:
    assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside an access phase");
  chk_err_decode:
    assert property (s_done |-> pslverr == !mapped) else $error("pslverr wrong for index");
  chk_read_upper:
    assert property (s_done ##0 !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_power_zero:
    assert property (s_done ##0 (!pwrite && idx == 10'h087) |-> prdata[1:0] == 2'b00)
    else $error("power control low bits not zero");
  chk_power_out:
    assert property (done_w && idx == 10'h087 |-> ##2
      (serial_rate_double == power_q[7] && code_store_write_mode == power_q[4]))
    else $error("power control outputs do not follow write");
  chk_ptr_select:
    assert property (quiet_q > 3'h3 |->
      data_pointer_addr == (sel_q[0] ? {ptr1_hi_q, ptr1_lo_q} : {ptr0_hi_q, ptr0_lo_q}))
    else $error("selected data pointer wrong");
  chk_page_high:
    assert property (quiet_q > 3'h3 |-> paged_data_addr[DATA_ADDR_W-1 -: 8] == page_q)
    else $error("paged address high byte wrong");
endmodule

bind core_sfr_file core_sfr_file_monitor #(.CODE_ADDR_W(CODE_ADDR_W), .DATA_ADDR_W(DATA_ADDR_W))
  mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .data_pointer_addr(data_pointer_addr), .paged_data_addr(paged_data_addr),
  .serial_rate_double(serial_rate_double), .code_store_write_mode(code_store_write_mode));

/* File: core_sfr_map.vh */
// Purpose: offsets, field positions, reset values of the core register set
// Assumes: apb byte address = sfr offset * 4 (offsets are not word multiples)
// Notes: sfr indices are one byte; scratch window sits above the sfr space
`ifndef CORE_SFR_MAP_VH
`define CORE_SFR_MAP_VH

`define SFR_STACK_IDX 8'h81
`define SFR_DPTR0_LO_IDX 8'h82
`define SFR_DPTR0_HI_IDX 8'h83
`define SFR_DPTR1_LO_IDX 8'h84
`define SFR_DPTR1_HI_IDX 8'h85
`define SFR_POWER_CTRL_IDX 8'h87
`define SFR_PTR_SELECT_IDX 8'h92
`define SFR_PAGE_HIGH_IDX 8'hC9
`define SFR_STATUS_IDX 8'hD0
`define SFR_OPERAND_IDX 8'hE0
`define SFR_AUX_IDX 8'hF0

// operation port and scratch window in the upper apb space
`define OP_CMD_IDX 10'h100
`define OP_ARG_IDX 10'h101
`define OP_INFO_IDX 10'h102
`define SCRATCH_BASE_IDX 10'h200

`define ST_CARRY 7
`define ST_HALF 6
`define ST_USER0 5
`define ST_BANK_HI 4
`define ST_BANK_LO 3
`define ST_RANGE 2
`define ST_USER1 1
`define ST_ODD 0

`define POWER_RATE_DOUBLE 7
`define POWER_CODE_WRITE 4
`define POWER_ZERO_MASK 8'hFC

`define STACK_RESET 8'h07
`define PAGE_RESET 8'h00
`define BYTE_RESET 8'h00

`define CMD_NONE 4'h0
`define CMD_ADD 4'h1
`define CMD_ADDC 4'h2
`define CMD_SUBB 4'h3
`define CMD_MUL 4'h4
`define CMD_DIV 4'h5
`define CMD_PUSH 4'h6
`define CMD_POP 4'h7
`define CMD_CALL 4'h8
`define CMD_RET 4'h9
`define CMD_SETC 4'hA
`define CMD_CLRC 4'hB
`define CMD_CPLC 4'hC
`define CMD_BITC 4'hD

`endif

/* File: operand_alu.v */
// Purpose: arithmetic for the main operand register and its flags
// Assumes: operand a is main_operand, b is the argument or multiply_aux
// Notes: divide by zero leaves operands and sets the range flag
`include "core_sfr_map.vh"
module operand_alu (
  input wire [3:0] cmd,
  input wire [7:0] a,
  input wire [7:0] b,
  input wire carry_in,
  output reg [7:0] res_a,
  output reg [7:0] res_b,
  output reg carry_out,
  output reg half_out,
  output reg range_out
);
  reg [8:0] sum;
  reg [4:0] nib;
  reg [15:0] prod;
  reg cin;

  always @* begin
    sum = 9'h000;
    nib = 5'h00;
    prod = 16'h0000;
    cin = (cmd == `CMD_ADD) ? 1'b0 : carry_in;
    res_a = a;
    res_b = b;
    carry_out = carry_in;
    half_out = 1'b0;
    range_out = 1'b0;
    case (cmd)
      `CMD_ADD, `CMD_ADDC: begin
        sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        res_a = sum[7:0];
        carry_out = sum[8];
        half_out = nib[4];
        range_out = (a[7] == b[7]) && (sum[7] != a[7]);
      end
      `CMD_SUBB: begin
        sum = {1'b0, a} - {1'b0, b} - {8'h00, carry_in};
        nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, carry_in};
        res_a = sum[7:0];
        carry_out = sum[8];
        half_out = nib[4];
        range_out = (a[7] != b[7]) && (sum[7] != a[7]);
      end
      `CMD_MUL: begin
        prod = a * b;
        res_a = prod[7:0];
        res_b = prod[15:8];
        carry_out = 1'b0;
        range_out = (prod[15:8] != 8'h00);
      end
      `CMD_DIV: begin
        carry_out = 1'b0;
        if (b == 8'h00) begin
          range_out = 1'b1;
        end else begin
          res_a = a / b;
          res_b = a % b;
        end
      end
      default: begin
        res_a = a;
      end
    endcase
  end
endmodule

/* File: scratch_ram.v */
// Purpose: 256-byte internal scratch memory, two ports
// Assumes: port a is the bus side, port b the operation engine
// Notes: a write on port b wins when both write the same byte
module scratch_ram (
  input wire pclk,
  input wire a_we,
  input wire [7:0] a_addr,
  input wire [7:0] a_wdata,
  output wire [7:0] a_rdata,
  input wire b_we,
  input wire [7:0] b_addr,
  input wire [7:0] b_wdata,
  output wire [7:0] b_rdata
);
  reg [7:0] mem [0:255];

  assign a_rdata = mem[a_addr];
  assign b_rdata = mem[b_addr];

  always @(posedge pclk) begin
    if (a_we && !(b_we && b_addr == a_addr)) begin
      mem[a_addr] <= a_wdata;
    end
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
  end
endmodule

/* File: tb.sv */
// Purpose: self-checking bench for the core register set over apb
// Assumes: one op command at a time, four idle cycles after it
// Notes: expected values are worked out by hand from the flag rules
`include "core_sfr_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire [31:0] prdata;
  wire pready, pslverr, serial_rate_double, code_store_write_mode;
  wire [15:0] data_pointer_addr, paged_data_addr;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] q;
  logic e;
  // cmd, status in, operand in, argument, operand out, aux out, status out, status mask
  logic [63:0] rows [6] = '{64'h01007F01805A45FF, 64'h0100FF0100A5C0FF, 64'h02800E01103C41FF,
    64'h03001020F0C380FF, 64'h04001020000204FF, 64'h05002305070001FF};

  core_sfr_file dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .data_pointer_addr(data_pointer_addr), .paged_data_addr(paged_data_addr),
    .serial_rate_double(serial_rate_double), .code_store_write_mode(code_store_write_mode));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 5000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [9:0] sx(input logic [7:0] i);
    return {2'b00, i};
  endfunction
  // one request held until pready, then one idle edge before the next
  task automatic xfer(input logic [9:0] idx, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, {24'h0, d});
  endtask
  task automatic rdx(input logic [9:0] idx, input logic [7:0] x);
    xfer(idx, 1'b0, 32'h0);
    chk({8'h00, q}, {8'h00, x});
    chk({15'h0, e}, 16'h0);
  endtask
  task automatic op(input logic [3:0] c, input logic [15:0] ra);
    xfer(`OP_CMD_IDX, 1'b1, {8'h00, ra, 4'h0, c});
    repeat (4) @(posedge pclk);
  endtask

  task automatic t_reset;
    rdx(sx(`SFR_STACK_IDX), `STACK_RESET);
    rdx(sx(`SFR_PAGE_HIGH_IDX), `PAGE_RESET);
    rdx(sx(`SFR_STATUS_IDX), `BYTE_RESET);
  endtask
  task automatic t_pointers;
    wr(sx(`SFR_DPTR0_LO_IDX), 8'h12);
    wr(sx(`SFR_DPTR0_HI_IDX), 8'h34);
    wr(sx(`SFR_DPTR1_LO_IDX), 8'h56);
    wr(sx(`SFR_DPTR1_HI_IDX), 8'h78);
    wr(sx(`SFR_PAGE_HIGH_IDX), 8'h80);
    chk(data_pointer_addr, 16'h3412);
    chk({8'h00, paged_data_addr[15:8]}, 16'h0080);
    wr(sx(`SFR_PTR_SELECT_IDX), 8'h01);
    chk(data_pointer_addr, 16'h7856);
    rdx(sx(`SFR_DPTR1_HI_IDX), 8'h78);
    wr(sx(`SFR_PTR_SELECT_IDX), 8'h00);
    chk(data_pointer_addr, 16'h3412);
  endtask
  task automatic t_power_control;
    wr(sx(`SFR_POWER_CTRL_IDX), 8'hFF);
    rdx(sx(`SFR_POWER_CTRL_IDX), 8'hFC);
    chk({14'h0, serial_rate_double, code_store_write_mode}, 16'h3);
    wr(sx(`SFR_POWER_CTRL_IDX), 8'h80);
    rdx(sx(`SFR_POWER_CTRL_IDX), 8'h80);
    chk({14'h0, serial_rate_double, code_store_write_mode}, 16'h2);
  endtask
  task automatic t_status;
    wr(sx(`SFR_OPERAND_IDX), 8'h07);
    rdx(sx(`SFR_STATUS_IDX), 8'h01);
    wr(sx(`SFR_STATUS_IDX), 8'hFE);
    rdx(sx(`SFR_STATUS_IDX), 8'hFF);
    wr(sx(`SFR_STATUS_IDX), 8'h00);
    rdx(sx(`SFR_STATUS_IDX), 8'h01);
    for (int b = 0; b < 4; b++)
      wr(`SCRATCH_BASE_IDX + 10'(b * 8 + 5), 8'(8'h40 + b));
    wr(`OP_ARG_IDX, 8'h05);
    for (int b = 0; b < 4; b++) begin
      wr(sx(`SFR_STATUS_IDX), 8'(b << 3));
      chk({8'h00, paged_data_addr[7:0]}, 16'(8'h40 + b));
    end
  endtask
  task automatic t_arith;
    for (int i = 0; i < 6; i++) begin
      wr(sx(`SFR_STATUS_IDX), rows[i][55:48]);
      wr(sx(`SFR_OPERAND_IDX), rows[i][47:40]);
      // add and subtract must leave aux at the value written here
      wr(sx(`SFR_AUX_IDX), rows[i][59:56] > 4'h3 ? rows[i][39:32] : rows[i][23:16]);
      wr(`OP_ARG_IDX, rows[i][39:32]);
      op(rows[i][59:56], 16'h0);
      rdx(sx(`SFR_OPERAND_IDX), rows[i][31:24]);
      rdx(sx(`SFR_AUX_IDX), rows[i][23:16]);
      xfer(sx(`SFR_STATUS_IDX), 1'b0, 32'h0);
      chk({8'h00, q & rows[i][7:0]}, {8'h00, rows[i][15:8]});
    end
  endtask
  task automatic t_stack;
    wr(`OP_ARG_IDX, 8'h33);
    op(`CMD_PUSH, 16'h0);
    rdx(sx(`SFR_STACK_IDX), 8'h08);
    rdx(`SCRATCH_BASE_IDX + 10'h008, 8'h33);
    op(`CMD_POP, 16'h0);
    rdx(`OP_INFO_IDX, 8'h33);
    rdx(sx(`SFR_STACK_IDX), 8'h07);
    op(`CMD_CALL, 16'h1234);
    rdx(sx(`SFR_STACK_IDX), 8'h09);
    rdx(`SCRATCH_BASE_IDX + 10'h008, 8'h34);
    rdx(`SCRATCH_BASE_IDX + 10'h009, 8'h12);
    op(`CMD_RET, 16'h0);
    rdx(sx(`SFR_STACK_IDX), 8'h07);
    rdx(`OP_INFO_IDX, 8'h34);
  endtask
  task automatic t_carry;
    for (int i = 0; i < 3; i++) begin
      op(i == 0 ? `CMD_SETC : (i == 1 ? `CMD_CLRC : `CMD_CPLC), 16'h0);
      xfer(sx(`SFR_STATUS_IDX), 1'b0, 32'h0);
      chk({15'h0, q[7]}, {15'h0, i != 1});
    end
    // bit 1 and bit 2 of the first bit byte, then operand bits 4 and 3
    wr(`SCRATCH_BASE_IDX + 10'h020, 8'h04);
    wr(sx(`SFR_OPERAND_IDX), 8'h08);
    for (int i = 0; i < 4; i++) begin
      wr(`OP_ARG_IDX, 8'(32'h0102E4E3 >> (24 - 8 * i)));
      op(`CMD_BITC, 16'h0);
      xfer(sx(`SFR_STATUS_IDX), 1'b0, 32'h0);
      chk({15'h0, q[7]}, {15'h0, i[0]});
    end
  endtask
  // the hole beside the pointer pair must refuse both directions
  task automatic t_unmapped;
    xfer(10'h086, 1'b1, 32'hFF);
    chk({15'h0, e}, 16'h1);
    xfer(10'h086, 1'b0, 32'h0);
    chk({7'h0, e, q}, 16'h0100);
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_pointers();
    t_power_control();
    t_status();
    t_arith();
    t_stack();
    t_carry();
    t_unmapped();
    final_report();
  end
endmodule
